// file: hw/lcd_port_pkg.sv
// shared constants and types of the LCD host port and display RAM
//
// Summary of operation
// R1: parallel select pin picks parallel bus or serial input; serial cannot read RAM.
// R2: bus style select high picks enable plus direction, low picks separate strobes.
// R3: data select 1 is display data; 0 read is status, 0 write is command.
// R4: separate-strobe mode latches the data bus on the write strobe rising edge.
// R5: enable-style mode: enable high strobes access, direction high reads, low writes.
// R6: serial input accepted only while low select is low and high select is high.
// R7: one serial bit sampled per rising serial clock, most significant bit first.
// R8: eighth rising serial clock hands the shifted bits on as one byte.
// R9: data select sampled at every eighth serial edge: low command, high data.
// R10: while not selected, serial shift register and bit counter return to initial state.
// R11: any other select combination floats the bus and ignores strobes and data select.
// R12: first data read after address set returns holder; second returns addressed data.
// R13: host inserts one dummy data read after address set and after writes.
// R14: written data waits in the holder and reaches RAM before the next write.
// R15: while busy, every access except a status read is rejected.
// R16: status read shows the busy flag on data bit 7.
// R17: display RAM is 65 rows by 132 columns, page and column, bit 0 on top.
// R18: page 8 is the single extra row; only data bit 0 is used there.
// R19: the page address never changes by itself.
// R20: column steps by one per data write and per non-dummy data read and stops at 0x83.
// R21: segment direction 1 reverses columns so column 0x83 drives the first segment.
// R22: start line picks the row on the top common line; 65 lines follow, scrolling.
// R23: display refresh reads are independent of host RAM accesses.
// R24: command bytes go to an outside decoder, whose address loads update these registers.
package lcd_port_pkg;

	// ----------------------------------------
	// display RAM geometry
	// ----------------------------------------
	localparam int COL_COUNT = 132;
	localparam int PAGE_COUNT = 9;
	localparam int ROW_COUNT = 65;
	localparam int RAM_WORDS = COL_COUNT * PAGE_COUNT;
	localparam logic [7:0] COL_LAST = 8'h83;
	localparam logic [3:0] EXTRA_PAGE = 4'h8;
	localparam logic [6:0] ROW_LAST = 7'h40;
	localparam logic [6:0] COM_LAST = 7'h3F;
	localparam logic [6:0] ROW_COUNT_W = 7'h41;

	// ----------------------------------------
	// bus fields and reset values
	// ----------------------------------------
	localparam int BUSY_BIT = 7;
	localparam logic [2:0] SERIAL_LAST_BIT = 3'h7;
	localparam logic [7:0] COLUMN_RESET = 8'h00;
	localparam logic [3:0] PAGE_RESET = 4'h0;
	localparam logic [5:0] START_RESET = 6'h00;

	typedef enum logic [2:0]
	{
		ACC_NONE = 3'b000,
		ACC_DATA_RD = 3'b001,
		ACC_DATA_WR = 3'b010,
		ACC_STAT_RD = 3'b011,
		ACC_CMD_WR = 3'b100
	} access_e;

	typedef struct packed
	{
		logic page_load;
		logic [3:0] page;
		logic column_load;
		logic [7:0] column;
		logic start_load;
		logic [5:0] start;
		logic direction_load;
		logic seg_reverse;
		logic com_reverse;
	} addr_load_s;

endpackage

// file: hw/serial_shifter.sv
// write-only serial receiver turning eight clocked bits into a byte
`timescale 1ns/10ps
module serial_shifter
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire logic active_i,
	input wire logic serial_clock_i,
	input wire logic serial_data_i,
	input wire logic data_not_command_i,
	output logic [7:0] byte_o,
	output logic byte_is_data_o,
	output logic byte_valid_o
);
	import lcd_port_pkg::*;

	logic clock_q;
	logic rise;
	logic last_bit;
	logic [2:0] bit_count;
	logic [6:0] shift;

	// ----------------------------------------
	// edge detection
	// ----------------------------------------
	// history keeps tracking while idle so a clock high at select is no edge
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			clock_q <= 1'b0;
		else if (ce_i)
			clock_q <= serial_clock_i;
	end

	assign rise = serial_clock_i && !clock_q;
	assign last_bit = active_i && rise && bit_count == SERIAL_LAST_BIT;

	// ----------------------------------------
	// shift register
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			bit_count <= 3'h0;
			shift <= 7'h00;
		end
		else if (ce_i)
		begin
			if (!active_i)
			begin
				bit_count <= 3'h0; // see R10
				shift <= 7'h00;
			end
			else if (rise) // see R6
			begin
				shift <= {shift[5:0], serial_data_i}; // see R7
				bit_count <= bit_count + 3'h1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			byte_o <= 8'h00;
			byte_is_data_o <= 1'b0;
			byte_valid_o <= 1'b0;
		end
		else if (ce_i)
		begin
			byte_valid_o <= last_bit; // see R8
			if (last_bit)
			begin
				byte_o <= {shift, serial_data_i};
				byte_is_data_o <= data_not_command_i; // see R9
			end
		end
	end

	serial_reset_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see R10
		(ce_i && !active_i) |=> bit_count == 3'h0 && shift == 7'h00)
		else $error("serial state not cleared while deselected");

	byte_on_eighth_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see R8
		(ce_i && active_i && rise && bit_count == 3'h7) |=> byte_valid_o)
		else $error("no byte after eighth serial edge");

	byte_kind_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see R9
		(ce_i && last_bit) |=> byte_is_data_o == $past(data_not_command_i))
		else $error("byte kind not taken from data select");

endmodule

// file: hw/lcd_host_port.sv
// host bus front end, bus holder and display RAM addressing
`timescale 1ns/10ps
module lcd_host_port
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire logic parallel_select_i,
	input wire logic bus_style_select_i,
	input wire logic chip_select_low_b_i,
	input wire logic chip_select_high_i,
	input wire logic data_not_command_i,
	input wire logic read_strobe_i,
	input wire logic write_strobe_i,
	input wire logic [7:0] data_i,
	input wire logic serial_data_i,
	input wire logic serial_clock_i,
	input wire logic busy_i,
	input wire lcd_port_pkg::addr_load_s addr_load_i,
	input wire logic [7:0] refresh_segment_i,
	input wire logic [6:0] refresh_common_i,
	output logic [7:0] data_o,
	output logic data_oe_o,
	output logic [7:0] command_o,
	output logic command_valid_o,
	output logic refresh_pixel_o
);
	import lcd_port_pkg::*;

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic selected;
	logic par_sel;
	logic ser_sel;
	logic read_q;
	logic write_q;
	logic rd_start;
	logic rd_hold;
	logic wr_take;
	access_e access;
	logic [7:0] wr_byte;
	logic [7:0] ser_byte;
	logic ser_is_data;
	logic ser_valid;
	logic [7:0] ram [0:RAM_WORDS-1];
	logic [7:0] holder;
	logic dummy_due;
	logic commit_due;
	logic [10:0] commit_index;
	logic [7:0] column;
	logic [7:0] next_column;
	logic [3:0] page;
	logic [5:0] start_line;
	logic seg_reverse;
	logic com_reverse;
	logic [7:0] refresh_col;
	logic [6:0] refresh_line;
	logic [6:0] refresh_row;

	function automatic logic [10:0] ram_index(input logic [3:0] p,
		input logic [7:0] c);
		ram_index = 11'(int'(p) * COL_COUNT) + 11'(c); // see R17
	endfunction

	// ----------------------------------------
	// chip select and mode
	// ----------------------------------------
	assign selected = !chip_select_low_b_i && chip_select_high_i; // see R11
	assign par_sel = selected && parallel_select_i; // see R1
	assign ser_sel = selected && !parallel_select_i; // see R6

	// ----------------------------------------
	// strobe history
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			read_q <= 1'b1;
			write_q <= 1'b1;
		end
		else if (ce_i)
		begin
			read_q <= read_strobe_i;
			write_q <= write_strobe_i;
		end
	end

	// enable style latches on the falling enable, using the direction held
	// before it so a late direction change cannot turn a write into a read
	always_comb
	begin
		rd_start = 1'b0;
		rd_hold = 1'b0;
		wr_take = 1'b0;
		if (bus_style_select_i) // see R2
		begin
			rd_start = read_strobe_i && !read_q && write_strobe_i; // see R5
			rd_hold = read_strobe_i && write_strobe_i;
			wr_take = !read_strobe_i && read_q && !write_q; // see R5
		end
		else
		begin
			rd_start = !read_strobe_i && read_q;
			rd_hold = !read_strobe_i;
			wr_take = write_strobe_i && !write_q; // see R4
		end
	end

	// ----------------------------------------
	// serial receiver
	// ----------------------------------------
	serial_shifter serial_rx
	(
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.ce_i(ce_i),
		.active_i(ser_sel),
		.serial_clock_i(serial_clock_i),
		.serial_data_i(serial_data_i),
		.data_not_command_i(data_not_command_i),
		.byte_o(ser_byte),
		.byte_is_data_o(ser_is_data),
		.byte_valid_o(ser_valid)
	);

	// ----------------------------------------
	// access decode
	// ----------------------------------------
	always_comb
	begin
		access = ACC_NONE;
		wr_byte = data_i;
		if (par_sel && rd_start)
			access = data_not_command_i ? ACC_DATA_RD : ACC_STAT_RD; // see R3
		else if (par_sel && wr_take)
			access = data_not_command_i ? ACC_DATA_WR : ACC_CMD_WR; // see R3
		else if (ser_valid)
		begin
			access = ser_is_data ? ACC_DATA_WR : ACC_CMD_WR; // see R9
			wr_byte = ser_byte;
		end
		if (busy_i && access != ACC_STAT_RD)
			access = ACC_NONE; // see R15
	end

	// column stops at the last address and never spills into the next page
	assign next_column = (column == COL_LAST) ? column :
		column + 8'h01; // see R20

	// ----------------------------------------
	// bus holder, column and dummy read tracking
	// ----------------------------------------
	// a read hands out the holder and refills it; after an address change or
	// a write the holder is stale, so that read leaves the column in place
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			holder <= 8'h00;
			dummy_due <= 1'b1;
			commit_due <= 1'b0;
			commit_index <= 11'h000;
			column <= COLUMN_RESET;
		end
		else if (ce_i)
		begin
			commit_due <= 1'b0;
			case (access)
				ACC_DATA_RD:
				begin
					if (dummy_due) // see R12
						holder <= ram[ram_index(page, column)];
					else
					begin
						holder <= ram[ram_index(page, next_column)];
						column <= next_column; // see R20
					end
					dummy_due <= 1'b0;
				end
				ACC_DATA_WR:
				begin
					if (page == EXTRA_PAGE)
						holder <= {7'h00, wr_byte[0]}; // see R18
					else
						holder <= wr_byte; // see R14
					commit_due <= 1'b1;
					commit_index <= ram_index(page, column);
					column <= next_column; // see R20
					dummy_due <= 1'b1; // see R13
				end
				default:
				begin
				end
			endcase
			if (addr_load_i.column_load) // see R24
				column <= addr_load_i.column;
			if (addr_load_i.column_load || addr_load_i.page_load)
				dummy_due <= 1'b1; // see R12
		end
	end

	// ----------------------------------------
	// page, start line and direction
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			page <= PAGE_RESET;
		else if (ce_i && addr_load_i.page_load)
			page <= addr_load_i.page; // see R19
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			start_line <= START_RESET;
		else if (ce_i && addr_load_i.start_load)
			start_line <= addr_load_i.start; // see R22
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			seg_reverse <= 1'b0;
			com_reverse <= 1'b0;
		end
		else if (ce_i && addr_load_i.direction_load)
		begin
			seg_reverse <= addr_load_i.seg_reverse; // see R21
			com_reverse <= addr_load_i.com_reverse; // see R22
		end
	end

	// ----------------------------------------
	// display RAM, host side
	// ----------------------------------------
	// commit one cycle after the write, well before any next write arrives
	always_ff @(posedge clk_i)
	begin
		if (ce_i && commit_due)
			ram[commit_index] <= holder; // see R14
	end

	// ----------------------------------------
	// display RAM, refresh side
	// ----------------------------------------
	// own read port, so host traffic never stalls or tears the refresh
	always_comb
	begin
		if (seg_reverse)
			refresh_col = COL_LAST - refresh_segment_i; // see R21
		else
			refresh_col = refresh_segment_i;
		if (com_reverse && refresh_common_i <= COM_LAST)
			refresh_line = COM_LAST - refresh_common_i; // see R22
		else
			refresh_line = refresh_common_i;
		refresh_row = {1'b0, start_line} + refresh_line;
		if (refresh_row > ROW_LAST)
			refresh_row = refresh_row - ROW_COUNT_W; // see R22
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			refresh_pixel_o <= 1'b0;
		else if (ce_i) // see R23
			refresh_pixel_o <= ram[ram_index(refresh_row[6:3],
				refresh_col)][refresh_row[2:0]]; // see R17
	end

	// ----------------------------------------
	// data bus output
	// ----------------------------------------
	// other status bits are not modelled here and read as zero
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			data_o <= 8'h00;
			data_oe_o <= 1'b0;
		end
		else if (ce_i)
		begin
			data_oe_o <= par_sel && rd_hold; // see R1
			if (access == ACC_STAT_RD)
			begin
				data_o <= 8'h00;
				data_o[BUSY_BIT] <= busy_i; // see R16
			end
			else if (access == ACC_DATA_RD)
				data_o <= holder; // see R12
		end
	end

	// ----------------------------------------
	// command hand-off
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			command_o <= 8'h00;
			command_valid_o <= 1'b0;
		end
		else if (ce_i)
		begin
			command_valid_o <= access == ACC_CMD_WR; // see R24
			if (access == ACC_CMD_WR)
				command_o <= wr_byte;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	status_busy_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see R16
		(ce_i && access == ACC_STAT_RD) |=> data_o[7] == $past(busy_i))
		else $error("status read lost busy flag");

	bus_float_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see R11
		(ce_i && !selected) |=> !data_oe_o)
		else $error("bus driven while deselected");

	serial_noread_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see R1
		(ce_i && !parallel_select_i) |=> !data_oe_o)
		else $error("bus driven in serial mode");

	busy_reject_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see R15
		(ce_i && busy_i) |=> !command_valid_o)
		else $error("command taken while busy");

	column_step_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see R20
		(ce_i && access == ACC_DATA_WR && column < 8'h83 &&
		!addr_load_i.column_load) |=> column == $past(column) + 8'h01)
		else $error("column did not step after write");

	column_stop_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see R20
		(ce_i && access == ACC_DATA_WR && column == 8'h83 &&
		!addr_load_i.column_load) |=> column == 8'h83)
		else $error("column moved past last address");

	page_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see R19
		(!addr_load_i.page_load) |=> $stable(page))
		else $error("page changed without a load");

	write_commit_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see R14
		(ce_i && access == ACC_DATA_WR) |=> commit_due ##1
		(!$past(ce_i) || ram[$past(commit_index)] == $past(holder)))
		else $error("written byte not committed");

	dummy_read_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see R12
		(ce_i && access == ACC_DATA_RD && dummy_due) |=>
		data_o == $past(holder) && column == $past(column))
		else $error("dummy read did not return holder");

endmodule

// file: verification/host_port_model.sv
// host processor model driving the parallel and serial pins
`timescale 1ns/10ps
module host_port_model
(
	input wire logic clk_i,
	output logic parallel_select_o,
	output logic bus_style_select_o,
	output logic chip_select_low_b_o,
	output logic chip_select_high_o,
	output logic data_not_command_o,
	output logic read_strobe_o,
	output logic write_strobe_o,
	output logic [7:0] data_o,
	output logic serial_data_o,
	output logic serial_clock_o
);
	initial
	begin
		parallel_select_o = 1'b1;
		bus_style_select_o = 1'b0;
		chip_select_low_b_o = 1'b0;
		chip_select_high_o = 1'b1;
		data_not_command_o = 1'b0;
		read_strobe_o = 1'b1;
		write_strobe_o = 1'b1;
		data_o = 8'h00;
		serial_data_o = 1'b0;
		serial_clock_o = 1'b0;
	end

	// ----------------------------------------
	// mode and select
	// ----------------------------------------
	task automatic set_mode(input logic par, input logic sty, input logic sel);
		@(posedge clk_i);
		parallel_select_o <= par;
		bus_style_select_o <= sty;
		chip_select_low_b_o <= ~sel;
		chip_select_high_o <= sel;
		read_strobe_o <= ~sty;
		write_strobe_o <= 1'b1;
		serial_clock_o <= 1'b0;
	endtask

	// ----------------------------------------
	// one parallel access, strobe held 3 cycles
	// ----------------------------------------
	task automatic access(input logic rd, input logic dnc, input logic [7:0] d);
		@(posedge clk_i);
		data_not_command_o <= dnc;
		data_o <= d;
		if (bus_style_select_o)
		begin
			read_strobe_o <= 1'b1;
			write_strobe_o <= rd;
		end
		else if (rd)
			read_strobe_o <= 1'b0;
		else
			write_strobe_o <= 1'b0;
		repeat (3) @(posedge clk_i);
		read_strobe_o <= ~bus_style_select_o;
		write_strobe_o <= 1'b1;
		repeat (3) @(posedge clk_i);
		// released bus shows no stale value
		data_o <= ~d;
	endtask

	// ----------------------------------------
	// serial frame of n bits, clock idles low
	// ----------------------------------------
	task automatic ser(input logic dnc, input logic [7:0] d, input int n);
		@(posedge clk_i);
		data_not_command_o <= dnc;
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk_i);
			serial_clock_o <= 1'b0;
			serial_data_o <= d[7 - i];
			@(posedge clk_i);
			serial_clock_o <= 1'b1;
		end
		@(posedge clk_i);
		serial_clock_o <= 1'b0;
		serial_data_o <= ~serial_data_o;
		repeat (3) @(posedge clk_i);
	endtask
endmodule

// file: verification/lcd_host_port_and_ram_addressing_tb.sv
// self-checking bench of the LCD host port and RAM addressing
`timescale 1ns/10ps
module lcd_host_port_and_ram_addressing_tb;
	import lcd_port_pkg::*;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic busy, ps, bs, csl, csh, dnc, rds, wrs, sd, sc, oe, cv, pix;
	logic oe_q = 1'b0;
	logic ce = 1'b1;
	int rv;
	logic [7:0] hd, rd, cmd, seg, r0, r1, r2;
	logic [6:0] com;
	addr_load_s al;
	int n_fail = 0;
	int num_checks = 0;
	int seed = 32'h74bc;
	logic [8:0] exp_rd[$];
	logic [8:0] exp_cmd[$];

	always #5 clk_i = ~clk_i;

	host_port_model host (.clk_i(clk_i), .parallel_select_o(ps),
		.bus_style_select_o(bs), .chip_select_low_b_o(csl),
		.chip_select_high_o(csh), .data_not_command_o(dnc),
		.read_strobe_o(rds), .write_strobe_o(wrs), .data_o(hd),
		.serial_data_o(sd), .serial_clock_o(sc));

	lcd_host_port uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce),
		.parallel_select_i(ps), .bus_style_select_i(bs),
		.chip_select_low_b_i(csl), .chip_select_high_i(csh),
		.data_not_command_i(dnc), .read_strobe_i(rds),
		.write_strobe_i(wrs), .data_i(hd), .serial_data_i(sd),
		.serial_clock_i(sc), .busy_i(busy), .addr_load_i(al),
		.refresh_segment_i(seg), .refresh_common_i(com), .data_o(rd),
		.data_oe_o(oe), .command_o(cmd), .command_valid_o(cv),
		.refresh_pixel_o(pix));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	// bit 8 of an expectation marks a dummy read
	task automatic chk(input logic [7:0] got, input logic [8:0] exp);
		num_checks++;
		if (exp[8] !== 1'b1 && got !== exp[7:0])
		begin
			n_fail++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp[7:0]);
		end
	endtask

	task automatic conclude();
		$display("checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic set_addr(input logic [3:0] p, input logic [7:0] c,
		input logic [5:0] s, input logic rev);
		@(posedge clk_i);
		al <= '{1'b1, p, 1'b1, c, 1'b1, s, 1'b1, rev, 1'b0};
		@(posedge clk_i);
		al <= '0;
	endtask

	task automatic pixel(input logic [7:0] s, input logic [6:0] c,
		input logic e);
		@(posedge clk_i);
		seg <= s;
		com <= c;
		repeat (3) @(posedge clk_i);
		chk({7'h00, pix}, {8'h00, e});
	endtask

	// ----------------------------------------
	// result watcher: unexpected results fail against x
	// ----------------------------------------
	always @(posedge clk_i)
	begin
		oe_q <= oe;
		if (oe === 1'b1 && oe_q !== 1'b1)
			chk(rd, exp_rd.size() ? exp_rd.pop_front() : 9'h0XX);
		if (cv === 1'b1)
			chk(cmd, exp_cmd.size() ? exp_cmd.pop_front() : 9'h0XX);
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		busy = 1'b0;
		al = '0;
		seg = 8'h00;
		com = 7'h00;
		repeat (8) @(posedge clk_i);
		rst_b_i <= 1'b1;
		r0 = $random(seed);
		exp_cmd.push_back({1'b0, r0});
		host.access(1'b0, 1'b0, r0);
		busy <= 1'b1;
		exp_rd.push_back(9'h080);
		host.access(1'b1, 1'b0, 8'h00);
		host.access(1'b0, 1'b0, 8'h11);
		busy <= 1'b0;
		$display("test status and busy done");
		set_addr(4'h2, 8'h05, 6'h00, 1'b0);
		r0 = $random(seed);
		r1 = $random(seed);
		host.access(1'b0, 1'b1, r0);
		host.access(1'b0, 1'b1, r1);
		set_addr(4'h2, 8'h05, 6'h00, 1'b0);
		exp_rd.push_back(9'h100);
		exp_rd.push_back({1'b0, r0});
		exp_rd.push_back({1'b0, r1});
		repeat (3) host.access(1'b1, 1'b1, 8'h00);
		$display("test data read back done");
		// column sticks at the last one, third write overwrites it
		set_addr(4'h2, 8'h82, 6'h00, 1'b0);
		r0 = $random(seed);
		r1 = $random(seed);
		r2 = $random(seed);
		host.access(1'b0, 1'b1, r0);
		host.access(1'b0, 1'b1, r1);
		host.access(1'b0, 1'b1, r2);
		set_addr(4'h2, 8'h82, 6'h00, 1'b0);
		exp_rd.push_back(9'h100);
		exp_rd.push_back({1'b0, r0});
		exp_rd.push_back({1'b0, r2});
		exp_rd.push_back({1'b0, r2});
		repeat (4) host.access(1'b1, 1'b1, 8'h00);
		set_addr(4'h8, 8'h0A, 6'h00, 1'b0);
		host.access(1'b0, 1'b1, 8'hFF);
		set_addr(4'h8, 8'h0A, 6'h00, 1'b0);
		exp_rd.push_back(9'h100);
		exp_rd.push_back(9'h001);
		repeat (2) host.access(1'b1, 1'b1, 8'h00);
		$display("test column end and extra page done");
		host.set_mode(1'b1, 1'b0, 1'b0);
		host.access(1'b0, 1'b0, 8'h5A);
		host.access(1'b1, 1'b1, 8'h00);
		host.set_mode(1'b1, 1'b1, 1'b1);
		r0 = $random(seed);
		exp_cmd.push_back({1'b0, r0});
		host.access(1'b0, 1'b0, r0);
		set_addr(4'h3, 8'h14, 6'h00, 1'b0);
		r1 = $random(seed);
		host.access(1'b0, 1'b1, r1);
		set_addr(4'h3, 8'h14, 6'h00, 1'b0);
		exp_rd.push_back(9'h100);
		exp_rd.push_back({1'b0, r1});
		repeat (2) host.access(1'b1, 1'b1, 8'h00);
		$display("test deselect and enable style done");
		host.set_mode(1'b0, 1'b0, 1'b1);
		r0 = $random(seed);
		exp_cmd.push_back({1'b0, r0});
		host.ser(1'b0, r0, 8);
		host.ser(1'b0, 8'hFF, 5);
		host.set_mode(1'b0, 1'b0, 1'b0);
		host.set_mode(1'b0, 1'b0, 1'b1);
		r1 = $random(seed);
		exp_cmd.push_back({1'b0, r1});
		host.ser(1'b0, r1, 8);
		set_addr(4'h4, 8'h07, 6'h00, 1'b0);
		r2 = $random(seed);
		host.ser(1'b1, r2, 8);
		host.access(1'b1, 1'b1, 8'h00);
		host.set_mode(1'b1, 1'b0, 1'b1);
		set_addr(4'h4, 8'h07, 6'h00, 1'b0);
		exp_rd.push_back(9'h100);
		exp_rd.push_back({1'b0, r2});
		repeat (2) host.access(1'b1, 1'b1, 8'h00);
		$display("test serial done");
		set_addr(4'h0, 8'h00, 6'h00, 1'b0);
		host.access(1'b0, 1'b1, 8'h02);
		pixel(8'h00, 7'h01, 1'b1);
		pixel(8'h00, 7'h00, 1'b0);
		set_addr(4'h0, 8'h00, 6'h00, 1'b1);
		pixel(8'h83, 7'h01, 1'b1);
		set_addr(4'h0, 8'h00, 6'h01, 1'b0);
		pixel(8'h00, 7'h00, 1'b1);
		// common reversal only, start line stays at 1
		al <= '{1'b0, 4'h0, 1'b0, 8'h00, 1'b0, 6'h00, 1'b1, 1'b0, 1'b1};
		@(posedge clk_i);
		al <= '0;
		pixel(8'h00, 7'h3F, 1'b1);
		pixel(8'h00, 7'h3E, 1'b0);
		set_addr(4'h0, 8'h00, 6'h00, 1'b0);
		r0 = $random(seed);
		r1 = $random(seed);
		host.access(1'b0, 1'b1, r0);
		pixel(8'h00, {4'h0, r1[2:0]}, r0[r1[2:0]]);
		$display("test refresh done");
		// frozen clock enable: a whole write passes unseen
		ce <= 1'b0;
		host.access(1'b0, 1'b0, r1);
		ce <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			rv = $random(seed);
			busy <= rv[8];
			if (!rv[8])
				exp_cmd.push_back({1'b0, rv[7:0]});
			host.access(1'b0, 1'b0, rv[7:0]);
		end
		busy <= 1'b0;
		$display("test freeze and random busy done");
		for (int i = 0; i < 50 && exp_rd.size() + exp_cmd.size() > 0; i++)
			@(posedge clk_i);
		if (exp_rd.size() + exp_cmd.size() > 0)
			n_fail++;
		conclude();
	end
endmodule
